/* hw/pcrb_reg_bank.v */
`include "pcrb_defines.vh"

module pcrb_reg_bank #(
  parameter SLOTS = `PCRB_OTP_SLOTS
) (
  // clock and reset
  input  wire        mclk_in,
  input  wire        rst_n_in,
  input  wire        hw_reset_in,
  // serial bus pins
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe_out,
  input  wire        slave_address_select_pin_in,
  // status from the port logic
  input  wire [7:0]  cc_detect_state_in,
  input  wire [7:0]  voltage_monitor_state_in,
  input  wire [7:0]  cc_link_state_in,
  input  wire [7:0]  fault_state_in,
  input  wire [7:0]  vbus_path_state_in,
  input  wire [7:0]  handshake_event_in,
  // default store programming
  input  wire        otp_prog_en_in,
  input  wire [15:0] otp_password_in,
  input  wire        otp_wr_in,
  input  wire [2:0]  otp_addr_in,
  input  wire [7:0]  otp_data_in,
  output wire        otp_burned_out,
  // interrupt and device reset
  output wire        alert_n_out,
  output wire        dev_reset_out,
  // configuration to the port logic
  output wire [7:0]  cc_capability_config_out,
  output wire [7:0]  vconn_current_limit_config_out,
  output wire [7:0]  fsm_sync_control_out,
  output wire [7:0]  vconn_monitor_config_out,
  output wire [7:0]  vbus_target_dac_out,
  output wire [7:0]  vbus_range_config_out,
  output wire [7:0]  powered_accessory_config_out,
  output wire [7:0]  vbus_discharge_timing_out,
  output wire [7:0]  vbus_discharge_control_out,
  output wire [7:0]  port_role_config_out,
  output wire [7:0]  vbus_monitor_config_out
);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_ADDR = 4'h1;
  localparam [3:0] S_AACK = 4'h2;
  localparam [3:0] S_REG  = 4'h3;
  localparam [3:0] S_RACK = 4'h4;
  localparam [3:0] S_WR   = 4'h5;
  localparam [3:0] S_WACK = 4'h6;
  localparam [3:0] S_RD   = 4'h7;
  localparam [3:0] S_MACK = 4'h8;
  localparam [2:0] LAST   = SLOTS[2:0] - 3'h1;

  // serial engine
  reg  [3:0] state_r;
  reg  [3:0] cnt_r;
  reg  [7:0] sh_r;
  reg  [7:0] tx_r;
  reg  [7:0] ptr_r;
  reg        rw_r;
  reg        mack_r;
  reg        sda_oe_r;
  reg        sda_out_r;
  reg        scl_q_r;
  reg        scl_d_r;
  reg        sda_q_r;
  reg        sda_d_r;
  reg  [7:0] rd_byte;

  // reset and default load
  reg        init_r;
  reg        load_r;
  reg  [2:0] ld_idx_r;
  reg        ld_vld_r;
  reg  [2:0] ld_widx_r;
  wire [7:0] ld_data;

  // registers
  reg  [7:0] alert_r;
  reg        alert_n_r;
  reg  [7:0] mask_r;
  reg  [7:0] cap_r;
  reg  [7:0] ilim_r;
  reg  [7:0] fsmc_r;
  reg  [7:0] vcmon_r;
  reg  [7:0] vtgt_r;
  reg  [7:0] vrange_r;
  reg  [7:0] srst_r;
  reg  [7:0] pacc_r;
  reg  [7:0] dtime_r;
  reg  [7:0] dctl_r;
  reg  [7:0] role_r;
  reg  [7:0] vbmon_r;
  wire [7:0] cc_chg;
  wire [7:0] mon_chg;
  wire [7:0] flt_chg;
  wire       cc_set;
  wire       mon_set;
  wire       flt_set;

  // bus events, taken from the registered pins
  wire scl_rise  = scl_q_r & ~scl_d_r;
  wire scl_fall  = ~scl_q_r & scl_d_r;
  wire bus_start = scl_q_r & scl_d_r & sda_d_r & ~sda_q_r;
  wire bus_stop  = scl_q_r & scl_d_r & ~sda_d_r & sda_q_r;
  wire byte_in   = scl_fall & (cnt_r == 4'h8);
  wire addr_hit  = (sh_r[7:1] == {`PCRB_DEV_ADDR_HI, slave_address_select_pin_in});
  wire rd_load   = ~bus_start & ~bus_stop & scl_fall &
                   (((state_r == S_AACK) & rw_r) | ((state_r == S_MACK) & ~mack_r));
  wire wr_stb    = ~bus_start & ~bus_stop & byte_in & (state_r == S_WR);
  wire soft_req  = wr_stb & (ptr_r == `PCRB_A_SRST) & sh_r[`PCRB_SW_RESET_BIT];

  // a read clears the addressed read-then-clear register in the cycle it is captured
  wire clr_alert = rd_load & (ptr_r == `PCRB_A_ALERT);
  wire clr_cc    = rd_load & (ptr_r == `PCRB_A_CC_CHG);
  wire clr_mon   = rd_load & (ptr_r == `PCRB_A_MON_CHG);
  wire clr_flt   = rd_load & (ptr_r == `PCRB_A_FLT_CHG);

  assign sda_out                        = sda_out_r;
  assign sda_oe_out                     = sda_oe_r;
  assign alert_n_out                    = alert_n_r;
  assign dev_reset_out                  = init_r;
  assign cc_capability_config_out       = cap_r;
  assign vconn_current_limit_config_out = ilim_r;
  assign fsm_sync_control_out           = fsmc_r;
  assign vconn_monitor_config_out       = vcmon_r;
  assign vbus_target_dac_out            = vtgt_r;
  assign vbus_range_config_out          = vrange_r;
  assign powered_accessory_config_out   = pacc_r;
  assign vbus_discharge_timing_out      = dtime_r;
  assign vbus_discharge_control_out     = dctl_r;
  assign port_role_config_out           = role_r;
  assign vbus_monitor_config_out        = vbmon_r;

  pcrb_change_latch #(.W(8)) u_cc_chg (
    .mclk_in       (mclk_in),
    .rst_n_in      (rst_n_in),
    .init_in       (init_r),
    .state_in      (cc_detect_state_in),
    .event_in      (8'h00),
    .read_clear_in (clr_cc),
    .latch_out     (cc_chg),
    .set_out       (cc_set)
  );

  pcrb_change_latch #(.W(8)) u_mon_chg (
    .mclk_in       (mclk_in),
    .rst_n_in      (rst_n_in),
    .init_in       (init_r),
    .state_in      (voltage_monitor_state_in),
    .event_in      (handshake_event_in),
    .read_clear_in (clr_mon),
    .latch_out     (mon_chg),
    .set_out       (mon_set)
  );

  pcrb_change_latch #(.W(8)) u_flt_chg (
    .mclk_in       (mclk_in),
    .rst_n_in      (rst_n_in),
    .init_in       (init_r),
    .state_in      (fault_state_in),
    .event_in      (8'h00),
    .read_clear_in (clr_flt),
    .latch_out     (flt_chg),
    .set_out       (flt_set)
  );

  pcrb_default_store #(.SLOTS(SLOTS)) u_store (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .rd_addr_in   (ld_idx_r),
    .rd_data_out  (ld_data),
    .prog_en_in   (otp_prog_en_in),
    .password_in  (otp_password_in),
    .prog_wr_in   (otp_wr_in),
    .prog_addr_in (otp_addr_in),
    .prog_data_in (otp_data_in),
    .burned_out   (otp_burned_out)
  );

  // read data; reserved and unmapped addresses read zero
  always @* begin
    case (ptr_r)
      `PCRB_A_ALERT:     rd_byte = alert_r;
      `PCRB_A_MASK:      rd_byte = mask_r;
      `PCRB_A_CC_CHG:    rd_byte = cc_chg;
      `PCRB_A_CC_STATE:  rd_byte = cc_detect_state_in;
      `PCRB_A_MON_CHG:   rd_byte = mon_chg;
      `PCRB_A_MON_STATE: rd_byte = voltage_monitor_state_in;
      `PCRB_A_LINK:      rd_byte = cc_link_state_in;
      `PCRB_A_FLT_CHG:   rd_byte = flt_chg;
      `PCRB_A_FLT_STATE: rd_byte = fault_state_in;
      `PCRB_A_CAP:       rd_byte = cap_r;
      `PCRB_A_ILIM:      rd_byte = ilim_r;
      `PCRB_A_FSM_CTRL:  rd_byte = fsmc_r;
      `PCRB_A_VCMON:     rd_byte = vcmon_r;
      `PCRB_A_VTGT:      rd_byte = vtgt_r;
      `PCRB_A_VRANGE:    rd_byte = vrange_r;
      `PCRB_A_SRST:      rd_byte = srst_r;
      `PCRB_A_PACC:      rd_byte = pacc_r;
      `PCRB_A_DTIME:     rd_byte = dtime_r;
      `PCRB_A_DCTL:      rd_byte = dctl_r;
      `PCRB_A_VBUS_PATH: rd_byte = vbus_path_state_in;
      `PCRB_A_ROLE:      rd_byte = role_r;
      `PCRB_A_VBMON:     rd_byte = vbmon_r;
      default:           rd_byte = 8'h00;
    endcase
  end

  // serial slave: shift in on scl rise, drive sda after scl fall
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r   <= S_IDLE;
      cnt_r     <= 4'h0;
      sh_r      <= 8'h00;
      tx_r      <= 8'h00;
      ptr_r     <= 8'h00;
      rw_r      <= 1'b0;
      mack_r    <= 1'b1;
      sda_oe_r  <= 1'b0;
      sda_out_r <= 1'b0;
      scl_q_r   <= 1'b1;
      scl_d_r   <= 1'b1;
      sda_q_r   <= 1'b1;
      sda_d_r   <= 1'b1;
    end else begin
      scl_q_r   <= scl_in;
      scl_d_r   <= scl_q_r;
      sda_q_r   <= sda_in;
      sda_d_r   <= sda_q_r;
      sda_out_r <= 1'b0;
      if (bus_start) begin
        state_r  <= S_ADDR;
        cnt_r    <= 4'h0;
        sda_oe_r <= 1'b0;
      end else if (bus_stop) begin
        state_r  <= S_IDLE;
        sda_oe_r <= 1'b0;
      end else if (rd_load) begin
        tx_r     <= rd_byte;
        sda_oe_r <= ~rd_byte[7];
        cnt_r    <= 4'h0;
        ptr_r    <= ptr_r + 8'h01;
        state_r  <= S_RD;
      end else begin
        if (scl_rise) begin
          if (state_r == S_MACK) begin
            mack_r <= sda_q_r;
          end else if ((state_r == S_ADDR) || (state_r == S_REG) || (state_r == S_WR)) begin
            sh_r  <= {sh_r[6:0], sda_q_r};
            cnt_r <= cnt_r + 4'h1;
          end
        end
        if (scl_fall) begin
          case (state_r)
            S_ADDR: begin
              if (byte_in) begin
                cnt_r <= 4'h0;
                if (addr_hit) begin
                  rw_r     <= sh_r[0];
                  sda_oe_r <= 1'b1;
                  state_r  <= S_AACK;
                end else begin
                  state_r <= S_IDLE;
                end
              end
            end
            S_REG: begin
              if (byte_in) begin
                cnt_r    <= 4'h0;
                ptr_r    <= sh_r;
                sda_oe_r <= 1'b1;
                state_r  <= S_RACK;
              end
            end
            S_WR: begin
              // every data byte is acknowledged, writable or not
              if (byte_in) begin
                cnt_r    <= 4'h0;
                ptr_r    <= ptr_r + 8'h01;
                sda_oe_r <= 1'b1;
                state_r  <= S_WACK;
              end
            end
            S_AACK: begin
              sda_oe_r <= 1'b0;
              state_r  <= S_REG;
            end
            S_RACK, S_WACK: begin
              sda_oe_r <= 1'b0;
              state_r  <= S_WR;
            end
            S_RD: begin
              if (cnt_r == 4'h7) begin
                sda_oe_r <= 1'b0;
                state_r  <= S_MACK;
              end else begin
                tx_r     <= {tx_r[6:0], 1'b0};
                sda_oe_r <= ~tx_r[6];
                cnt_r    <= cnt_r + 4'h1;
              end
            end
            S_MACK: begin
              state_r <= S_IDLE;
            end
            default: begin
              state_r <= S_IDLE;
            end
          endcase
        end
      end
    end
  end

  // reset sequencing and default load from the store
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      init_r    <= 1'b1;
      load_r    <= 1'b0;
      ld_idx_r  <= 3'h0;
      ld_vld_r  <= 1'b0;
      ld_widx_r <= 3'h0;
    end else begin
      init_r    <= hw_reset_in | soft_req;
      ld_vld_r  <= load_r;
      ld_widx_r <= ld_idx_r;
      if (init_r) begin
        load_r   <= 1'b1;
        ld_idx_r <= 3'h0;
      end else if (load_r) begin
        if (ld_idx_r == LAST) begin
          load_r <= 1'b0;
        end
        ld_idx_r <= ld_idx_r + 3'h1;
      end
    end
  end

  // alert summary and interrupt pin
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      alert_r   <= 8'h00;
      alert_n_r <= 1'b1;
    end else begin
      if (init_r) begin
        alert_r <= 8'h00;
      end else begin
        alert_r <= (alert_r & ~{8{clr_alert}}) | {5'h00, flt_set, mon_set, cc_set};
      end
      alert_n_r <= ~|(alert_r & ~mask_r);
    end
  end

  // host registers; a load from the store outranks a host write
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mask_r   <= `PCRB_RST_MASK;
      cap_r    <= `PCRB_RST_CAP;
      ilim_r   <= `PCRB_RST_ILIM;
      fsmc_r   <= `PCRB_RST_ZERO;
      vcmon_r  <= `PCRB_RST_VCMON;
      vtgt_r   <= `PCRB_RST_ZERO;
      vrange_r <= `PCRB_RST_VRANGE;
      srst_r   <= `PCRB_RST_SRST;
      pacc_r   <= `PCRB_RST_ZERO;
      dtime_r  <= `PCRB_RST_DTIME;
      dctl_r   <= `PCRB_RST_ZERO;
      role_r   <= `PCRB_RST_ROLE;
      vbmon_r  <= `PCRB_RST_VBMON;
    end else if (init_r) begin
      fsmc_r  <= `PCRB_RST_ZERO;
      vcmon_r <= `PCRB_RST_VCMON;
      vtgt_r  <= `PCRB_RST_ZERO;
      srst_r  <= `PCRB_RST_SRST;
      pacc_r  <= `PCRB_RST_ZERO;
      dctl_r  <= `PCRB_RST_ZERO;
    end else if (ld_vld_r) begin
      case (ld_widx_r)
        `PCRB_SLOT_MASK:   mask_r   <= ld_data;
        `PCRB_SLOT_CAP:    cap_r    <= ld_data;
        `PCRB_SLOT_ILIM:   ilim_r   <= ld_data;
        `PCRB_SLOT_VRANGE: vrange_r <= ld_data;
        `PCRB_SLOT_DTIME:  dtime_r  <= ld_data;
        `PCRB_SLOT_ROLE:   role_r   <= ld_data;
        `PCRB_SLOT_VBMON:  vbmon_r  <= ld_data;
        default: begin
        end
      endcase
    end else if (wr_stb) begin
      case (ptr_r)
        `PCRB_A_MASK:     mask_r   <= sh_r;
        `PCRB_A_CAP:      cap_r    <= sh_r;
        `PCRB_A_ILIM:     ilim_r   <= sh_r;
        `PCRB_A_FSM_CTRL: fsmc_r   <= sh_r;
        `PCRB_A_VCMON:    vcmon_r  <= sh_r;
        `PCRB_A_VTGT:     vtgt_r   <= sh_r;
        `PCRB_A_VRANGE:   vrange_r <= sh_r;
        `PCRB_A_SRST:     srst_r   <= sh_r;
        `PCRB_A_PACC:     pacc_r   <= sh_r;
        `PCRB_A_DTIME:    dtime_r  <= sh_r;
        `PCRB_A_DCTL:     dctl_r   <= sh_r;
        `PCRB_A_ROLE:     role_r   <= sh_r;
        `PCRB_A_VBMON:    vbmon_r  <= sh_r;
        default: begin
          // read-only, reserved and unmapped addresses keep their state
        end
      endcase
    end
  end

endmodule // pcrb_reg_bank

/* hw/pcrb_defines.vh */
`ifndef PCRB_DEFINES_VH
`define PCRB_DEFINES_VH
// Summary of operation
// - A read-then-clear register returns its content on a read and is cleared by that read.
// - Read-only and reserved addresses return status or zero and ignore host writes.
// - The alert summary at 0Bh gathers pending change events and clears when it is read.
// - The host-writable alert mask at 0Ch keeps masked summary bits off the interrupt pin.
// - The CC detect change latch at 0Dh catches any change of 0Eh until a read clears it.
// - Register 0Fh reports state machine handshake events and changes of 10h, read-then-clear.
// - The fault change latch at 12h catches changes of 13h and clears on a host read.
// - The state machine sync control at 1Fh is host read/write and is handed to the port logic.
// - The soft reset control at 23h is host read/write and lets software reset the device.
// - After power-up and every reset each customisable bit is loaded from the default store.
// - A software value stays until rewritten or until a reset restores the stored default, or the fixed reset value for registers outside the store.
// - The default store can be reprogrammed once, behind a password, giving new defaults.
// - The serial slave answers 7-bit address 28h or 29h chosen by a pin, data MSB first.

// serial slave address, upper six bits; the select pin gives bit 0
`define PCRB_DEV_ADDR_HI   6'h14

// register offsets
`define PCRB_A_ALERT       8'h0B
`define PCRB_A_MASK        8'h0C
`define PCRB_A_CC_CHG      8'h0D
`define PCRB_A_CC_STATE    8'h0E
`define PCRB_A_MON_CHG     8'h0F
`define PCRB_A_MON_STATE   8'h10
`define PCRB_A_LINK        8'h11
`define PCRB_A_FLT_CHG     8'h12
`define PCRB_A_FLT_STATE   8'h13
`define PCRB_A_CAP         8'h18
`define PCRB_A_ILIM        8'h1E
`define PCRB_A_FSM_CTRL    8'h1F
`define PCRB_A_VCMON       8'h20
`define PCRB_A_VTGT        8'h21
`define PCRB_A_VRANGE      8'h22
`define PCRB_A_SRST        8'h23
`define PCRB_A_PACC        8'h24
`define PCRB_A_DTIME       8'h25
`define PCRB_A_DCTL        8'h26
`define PCRB_A_VBUS_PATH   8'h27
`define PCRB_A_ROLE        8'h28
`define PCRB_A_VBMON       8'h2E

// reset and factory default values
`define PCRB_RST_ZERO      8'h00
`define PCRB_RST_MASK      8'h07
`define PCRB_RST_CAP       8'h41
`define PCRB_RST_ILIM      8'h00
`define PCRB_RST_VCMON     8'h01
`define PCRB_RST_VRANGE    8'h75
`define PCRB_RST_SRST      8'h00
`define PCRB_RST_DTIME     8'hAA
`define PCRB_RST_ROLE      8'h03
`define PCRB_RST_VBMON     8'h10

// soft reset request bit in the soft reset control register
`define PCRB_SW_RESET_BIT  0

// default store slots
`define PCRB_OTP_SLOTS     7
`define PCRB_SLOT_MASK     3'h0
`define PCRB_SLOT_CAP      3'h1
`define PCRB_SLOT_ILIM     3'h2
`define PCRB_SLOT_VRANGE   3'h3
`define PCRB_SLOT_DTIME    3'h4
`define PCRB_SLOT_ROLE     3'h5
`define PCRB_SLOT_VBMON    3'h6

// customer password, value is arbitrary
`define PCRB_OTP_PASSWORD  16'hC0DE

`endif

/* hw/pcrb_change_latch.v */
`include "pcrb_defines.vh"

module pcrb_change_latch #(
  parameter W = 8
) (
  // clock and reset
  input  wire         mclk_in,
  input  wire         rst_n_in,
  input  wire         init_in,
  // watched state and extra events
  input  wire [W-1:0] state_in,
  input  wire [W-1:0] event_in,
  // host side
  input  wire         read_clear_in,
  output wire [W-1:0] latch_out,
  output wire         set_out
);

  reg  [W-1:0] prev_r;
  reg  [W-1:0] latch_r;
  reg          primed_r;
  wire [W-1:0] hits;

  // no change is flagged before the first init has sampled the state
  assign hits      = primed_r ? ((state_in ^ prev_r) | event_in) : {W{1'b0}};
  assign latch_out = latch_r;
  assign set_out   = |hits;

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_r   <= {W{1'b0}};
      latch_r  <= {W{1'b0}};
      primed_r <= 1'b0;
    end else if (init_in) begin
      prev_r   <= state_in;
      latch_r  <= {W{1'b0}};
      primed_r <= 1'b1;
    end else begin
      prev_r  <= state_in;
      // a change in the clearing cycle survives the clear
      latch_r <= (latch_r & ~{W{read_clear_in}}) | hits;
    end
  end

endmodule // pcrb_change_latch

/* hw/pcrb_default_store.v */
`include "pcrb_defines.vh"

module pcrb_default_store #(
  parameter SLOTS = `PCRB_OTP_SLOTS
) (
  // clock and power-on reset
  input  wire        mclk_in,
  input  wire        rst_n_in,
  // default read port
  input  wire [2:0]  rd_addr_in,
  output wire [7:0]  rd_data_out,
  // one-time programming port
  input  wire        prog_en_in,
  input  wire [15:0] password_in,
  input  wire        prog_wr_in,
  input  wire [2:0]  prog_addr_in,
  input  wire [7:0]  prog_data_in,
  output wire        burned_out
);

  reg [7:0] mem [0:SLOTS-1];
  reg [7:0] rd_data_r;
  reg       session_r;
  reg       burned_r;
  integer   i;

  function [7:0] factory;
    input [2:0] slot;
    begin
      case (slot)
        `PCRB_SLOT_MASK:   factory = `PCRB_RST_MASK;
        `PCRB_SLOT_CAP:    factory = `PCRB_RST_CAP;
        `PCRB_SLOT_ILIM:   factory = `PCRB_RST_ILIM;
        `PCRB_SLOT_VRANGE: factory = `PCRB_RST_VRANGE;
        `PCRB_SLOT_DTIME:  factory = `PCRB_RST_DTIME;
        `PCRB_SLOT_ROLE:   factory = `PCRB_RST_ROLE;
        `PCRB_SLOT_VBMON:  factory = `PCRB_RST_VBMON;
        default:           factory = `PCRB_RST_ZERO;
      endcase
    end
  endfunction

  wire pw_ok = (password_in == `PCRB_OTP_PASSWORD);

  assign rd_data_out = rd_data_r;
  assign burned_out  = burned_r;

  // limitation: only the power-on reset clears this model, so fuse state lives to power loss
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (i = 0; i < SLOTS; i = i + 1) begin
        mem[i] <= factory(i[2:0]);
      end
      rd_data_r <= 8'h00;
      session_r <= 1'b0;
      burned_r  <= 1'b0;
    end else begin
      rd_data_r <= (rd_addr_in < SLOTS) ? mem[rd_addr_in] : 8'h00;
      if (prog_en_in && pw_ok && !burned_r) begin
        session_r <= 1'b1;
        if (prog_wr_in && (prog_addr_in < SLOTS)) begin
          mem[prog_addr_in] <= prog_data_in;
        end
      end
      if (!prog_en_in && session_r) begin
        session_r <= 1'b0;
        burned_r  <= 1'b1;
      end
    end
  end

endmodule // pcrb_default_store

/* tb/pcrb_properties.sv */
`include "pcrb_defines.vh"
module pcrb_properties (
  // clock, resets and bus
  input wire logic       mclk_in,
  input wire logic       rst_n_in,
  input wire logic       hw_reset_in,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  // default store, alert and reset
  input wire logic       otp_prog_en_in,
  input wire logic       otp_burned_out,
  input wire logic       alert_n_out,
  input wire logic       dev_reset_out,
  // configuration
  input wire logic [7:0] fsm_sync_control_out,
  input wire logic [7:0] vbus_target_dac_out,
  input wire logic [7:0] vbus_range_config_out,
  input wire logic [7:0] port_role_config_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // the reload takes about eight cycles, so twelve leaves a little slack
  sequence reload_done;
    ##[1:12] (port_role_config_out == `PCRB_RST_ROLE && alert_n_out
      && vbus_range_config_out == `PCRB_RST_VRANGE && fsm_sync_control_out == 8'h00);
  endsequence
  sda_line_low_a: assert property (sda_out == 1'b0)
    else $error("sda data pin not low");
  pin_reset_init_a: assert property (hw_reset_in |=> dev_reset_out)
    else $error("reset pin gave no init");
  reload_defaults_a: assert property ($fell(dev_reset_out) |-> reload_done)
    else $error("defaults not reloaded");
  ack_pull_a: assert property ($rose(sda_oe_out) |-> !scl_in)
    else $error("sda pulled while scl high");
  ack_release_a: assert property ($fell(sda_oe_out) |-> !scl_in)
    else $error("sda released while scl high");
  burn_once_a: assert property (!$fell(otp_burned_out))
    else $error("default store unburned");
  burn_close_a: assert property ($rose(otp_burned_out) |-> !otp_prog_en_in)
    else $error("store burned while session open");
  // only a bus write or a device reset may move the VBUS target DAC value
  value_hold_a: assert property ($changed(vbus_target_dac_out) |->
    !scl_in || dev_reset_out || $past(dev_reset_out))
    else $error("config changed without cause");
endmodule // pcrb_properties

bind pcrb_reg_bank pcrb_properties chk_u (
  .mclk_in, .rst_n_in, .hw_reset_in, .scl_in, .sda_out, .sda_oe_out, .otp_prog_en_in,
  .otp_burned_out, .alert_n_out, .dev_reset_out, .fsm_sync_control_out,
  .vbus_target_dac_out, .vbus_range_config_out, .port_role_config_out
);

/* tb/pcrb_host_model.sv */
module pcrb_host_model (
  // clock and the device's pull-down
  input  wire logic mclk_in,
  input  wire logic dut_oe_in,
  // bus lines
  output wire logic scl_out,
  output wire logic sda_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_r = 1'b1;
  logic low_r = 1'b0;
  assign scl_out = scl_r;
  // pull-up: released line reads high
  assign sda_out = ~(low_r | dut_oe_in);
  task automatic tick();
    repeat (6) @(posedge mclk_in);
  endtask
  task automatic xfer(input logic b, output logic got);
    low_r <= ~b;
    tick();
    scl_r <= 1'b1;
    tick();
    got = sda_out;
    scl_r <= 1'b0;
    tick();
  endtask
  task automatic start();
    low_r <= 1'b0;
    tick();
    scl_r <= 1'b1;
    tick();
    low_r <= 1'b1;
    tick();
    scl_r <= 1'b0;
    tick();
  endtask
  task automatic stop();
    low_r <= 1'b1;
    tick();
    scl_r <= 1'b1;
    tick();
    low_r <= 1'b0;
    tick();
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) xfer(d[i], g);
    xfer(1'b1, g);
    ack = ~g;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
    xfer(last, g);
  endtask
endmodule // pcrb_host_model

/* tb/port_controller_register_bank_test.sv */
`include "pcrb_defines.vh"
module port_controller_register_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic       hw_reset_in = 1'b0;
  logic       sel = 1'b0;
  logic       prog = 1'b0;
  logic       owr = 1'b0;
  logic       k;
  logic [7:0] cc = 8'hA5;
  logic [7:0] mon = 8'h00;
  logic [7:0] flt = 8'h00;
  logic [7:0] hs = 8'h00;
  logic [7:0] odat = 8'h00;
  logic [15:0] pw = 16'h0000;
  wire        scl, sda, oe, alert_n, burned;
  wire  [7:0] fsm_ctl;
  int         failures = 0;
  int         n_checks = 0;
  logic [15:0] dflt [9] = '{16'h0C07, 16'h1841, 16'h1E00, 16'h2001, 16'h2275, 16'h2300,
                            16'h25AA, 16'h2803, 16'h2E10};
  logic [7:0] rw [12] = '{8'h0C, 8'h18, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h24, 8'h25,
                         8'h26, 8'h28, 8'h2E};
  logic [15:0] ro [11] = '{16'h3000, 16'h4000, 16'h8000, 16'hA000, 16'hC000, 16'hFF00,
                           16'h0EA5, 16'h1000, 16'h113C, 16'h1300, 16'h27C3};
  logic [7:0] rc [4] = '{8'h0B, 8'h0D, 8'h0F, 8'h12};
  always #2 mclk_in = ~mclk_in;
  pcrb_host_model h_u (.mclk_in, .dut_oe_in(oe), .scl_out(scl), .sda_out(sda));
  pcrb_reg_bank dut_u (
    .mclk_in, .rst_n_in, .hw_reset_in, .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe_out(oe), .slave_address_select_pin_in(sel), .cc_detect_state_in(cc),
    .voltage_monitor_state_in(mon), .cc_link_state_in(8'h3C), .fault_state_in(flt),
    .vbus_path_state_in(8'hC3), .handshake_event_in(hs), .otp_prog_en_in(prog),
    .otp_password_in(pw), .otp_wr_in(owr), .otp_addr_in(`PCRB_SLOT_CAP),
    .otp_data_in(odat), .otp_burned_out(burned), .alert_n_out(alert_n), .dev_reset_out(),
    .cc_capability_config_out(), .vconn_current_limit_config_out(),
    .fsm_sync_control_out(fsm_ctl), .vconn_monitor_config_out(), .vbus_target_dac_out(),
    .vbus_range_config_out(), .powered_accessory_config_out(),
    .vbus_discharge_timing_out(), .vbus_discharge_control_out(),
    .port_role_config_out(), .vbus_monitor_config_out()
  );
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic head(input logic [7:0] a);
    h_u.start();
    h_u.put_byte({`PCRB_DEV_ADDR_HI, sel, 1'b0}, k);
    chk("address ack", 8'h01, {7'h00, k});
    h_u.put_byte(a, k);
    chk("pointer ack", 8'h01, {7'h00, k});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    head(a);
    h_u.put_byte(d, k);
    chk("data ack", 8'h01, {7'h00, k});
    h_u.stop();
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    head(a);
    h_u.start();
    h_u.put_byte({`PCRB_DEV_ADDR_HI, sel, 1'b1}, k);
    h_u.get_byte(1'b1, d);
    h_u.stop();
    chk($sformatf("register %h", a), exp, d);
  endtask
  task automatic pin_reset();
    hw_reset_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    hw_reset_in <= 1'b0;
    repeat (20) @(posedge mclk_in);
  endtask
  task automatic burn(input logic [7:0] d, e);
    prog <= 1'b1;
    odat <= d;
    @(posedge mclk_in);
    owr <= 1'b1;
    @(posedge mclk_in);
    owr <= 1'b0;
    @(posedge mclk_in);
    prog <= 1'b0;
    repeat (3) @(posedge mclk_in);
    chk("store burned", {7'h00, e != `PCRB_RST_CAP}, {7'h00, burned});
    pin_reset();
    rchk(8'h18, e);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge mclk_in);
    failures++;
    $display("unexpected run length: expected end seen timeout");
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (20) @(posedge mclk_in);
    foreach (dflt[i]) rchk(dflt[i][15:8], dflt[i][7:0]);
    $display("defaults test done");
    foreach (rw[i]) wr(rw[i], rw[i] ^ 8'h5A);
    foreach (rw[i]) rchk(rw[i], rw[i] ^ 8'h5A);
    chk("sync control", 8'h45, fsm_ctl);
    foreach (ro[i]) wr(ro[i][15:8], 8'hFF);
    foreach (ro[i]) rchk(ro[i][15:8], ro[i][7:0]);
    rchk(8'h0C, 8'h56);
    $display("access test done");
    wr(8'h0C, 8'h00);
    cc <= 8'h5A;
    flt <= 8'h3C;
    mon <= 8'h10;
    hs <= 8'h81;
    @(posedge mclk_in);
    hs <= 8'h00;
    repeat (4) @(posedge mclk_in);
    chk("alert pin", 8'h00, {7'h00, alert_n});
    wr(8'h0C, 8'h07);
    chk("alert pin", 8'h01, {7'h00, alert_n});
    rchk(8'h0B, 8'h07);
    rchk(8'h0D, 8'hFF);
    rchk(8'h0F, 8'h91);
    rchk(8'h12, 8'h3C);
    foreach (rc[i]) rchk(rc[i], 8'h00);
    wr(8'h0C, 8'h00);
    chk("alert pin", 8'h01, {7'h00, alert_n});
    $display("event test done");
    wr(8'h23, 8'h01);
    repeat (20) @(posedge mclk_in);
    rchk(8'h0C, 8'h07);
    rchk(8'h23, 8'h00);
    wr(8'h18, 8'h00);
    pin_reset();
    rchk(8'h18, 8'h41);
    burn(8'h99, 8'h41);
    pw <= `PCRB_OTP_PASSWORD;
    burn(8'h22, 8'h22);
    burn(8'h99, 8'h22);
    $display("reset test done");
    sel <= 1'b1;
    h_u.start();
    h_u.put_byte(8'h50, k);
    chk("foreign address ack", 8'h00, {7'h00, k});
    h_u.stop();
    rchk(8'h0E, 8'h5A);
    $display("address test done");
    report_and_stop();
  end
endmodule // port_controller_register_bank_test
